// file: rtl/alt_function_remap_mux.sv
// Top of the alternate-function remap multiplexer with its option register.
// Assumes synchronous inputs at 20 MHz and a plain one-cycle register port.
`timescale 1ns/1ps
// Functional notes
// - Eight remap selection bits sit in one option byte, bits seven to zero.
// - A cleared selection bit leaves its pins on default alternate functions.
// - An active remap removes the default function from the affected pin.
// - Beeper_out remap puts the beeper output on port D pin 4.
// - I2C remap puts I2C data on port B pin 5, clock on pin 4.
// - Advanced timer remap puts trigger and complementary outputs on port B.
// - Channel 4 remap puts advanced timer channel 4 on its port D pin.
// - Break remap makes port D pin 0 the advanced timer break input.
// - Clock output remap puts the configurable clock on port D pin 0.
// - Clock output remap has priority over break remap on port D pin 0.
// - Channel swap exchanges timer 3 channel 1 and timer 2 channel 3 pins.
// - Converter trigger remap makes port D pin 3 the converter trigger.
// - Remapping leaves ordinary GPIO behaviour of the pins untouched.
// - Port F pin 4 pulled up during reset, floating afterwards.
// - Port D pin 1 keeps its pull-up during and after reset.
// - Analog input 12 cannot be chosen for scan or analog watchdog.
module alt_function_remap_mux
    import remap_pkg::*;
(
    input  wire logic       CLK_IN,
    input  wire logic       SYS_RST_IN,
    input  wire logic [1:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    output logic [7:0]      REG_RDATA_OUT,
    input  wire logic       TIMER2_CH1_IN,
    input  wire logic       TIMER2_CH2_IN,
    input  wire logic       TIMER2_CH3_IN,
    input  wire logic       TIMER3_CH1_IN,
    input  wire logic       TIMER3_CH2_IN,
    input  wire logic       BEEPER_OUT_IN,
    input  wire logic       ADV_TIMER_CH4_IN,
    input  wire logic       ADV_TIMER_COMP_CH1_IN,
    input  wire logic       ADV_TIMER_COMP_CH2_IN,
    input  wire logic       ADV_TIMER_COMP_CH3_IN,
    input  wire logic       CONFIGURABLE_CLOCK_OUT_IN,
    input  wire logic       I2C_SDA_OUT_IN,
    input  wire logic       I2C_SCL_OUT_IN,
    input  wire logic [7:0] PORTB_PIN_IN,
    input  wire logic [7:0] PORTD_PIN_IN,
    input  wire logic       PORTA_PIN3_IN,
    input  wire logic [3:0] CONV_CHANNEL_IN,
    input  wire logic       CONV_SCAN_OR_WDG_IN,
    output logic            PORTA3_AF_OUT,
    output logic [7:0]      PORTB_AF_OUT,
    output logic [7:0]      PORTB_AF_EN_OUT,
    output logic [7:0]      PORTD_AF_OUT,
    output logic [7:0]      PORTD_AF_EN_OUT,
    output logic            ADV_TIMER_EXT_TRIGGER_OUT,
    output logic            ADV_TIMER_BREAK_IN_OUT,
    output logic            CONVERTER_EXT_TRIGGER_OUT,
    output logic            I2C_SDA_IN_OUT,
    output logic            I2C_SCL_IN_OUT,
    output logic            TIMER3_CH1_CAPTURE_OUT,
    output logic            PORTF_PIN4_PULLUP_OUT,
    output logic            PORTD_PIN1_PULLUP_OUT,
    output logic            CONV_CHANNEL_OK_OUT
);
    // Option byte as written by software, and the routing latched from it
    logic [7:0] pin_remap_options;
    logic [7:0] next_pin_remap_options;
    logic [7:0] active_sel;
    logic [7:0] next_active_sel;
    logic       in_reset;
    logic       next_in_reset;
    logic [7:0] next_rdata;
    remap_sel_if sel_link ();
    logic              pd4_func;
    logic              pd2_func;
    logic              pa3_func;
    logic              pd0_func;
    logic              pd7_func;
    logic [3:0]        portb_func;
    pd0_owner_type     pd0_owner;
    logic [7:0]        next_pb_af;
    logic [7:0]        next_pb_en;
    logic [7:0]        next_pd_af;
    logic [7:0]        next_pd_en;
    logic              next_conv_ok;
    logic [7:0]        sel_bits;

    assign sel_link.sel = active_sel;
    assign sel_bits     = active_sel;

    remap_router router (
        .sel_bus                (sel_link),
        .timer2_ch1             (TIMER2_CH1_IN),
        .timer2_ch3             (TIMER2_CH3_IN),
        .timer3_ch1             (TIMER3_CH1_IN),
        .timer3_ch2             (TIMER3_CH2_IN),
        .beeper_out             (BEEPER_OUT_IN),
        .adv_timer_ch4          (ADV_TIMER_CH4_IN),
        .adv_timer_comp_ch1     (ADV_TIMER_COMP_CH1_IN),
        .adv_timer_comp_ch2     (ADV_TIMER_COMP_CH2_IN),
        .adv_timer_comp_ch3     (ADV_TIMER_COMP_CH3_IN),
        .configurable_clock_out (CONFIGURABLE_CLOCK_OUT_IN),
        .pin_level              (PORTD_PIN_IN),
        .pd4_func               (pd4_func),
        .pd2_func               (pd2_func),
        .pa3_func               (pa3_func),
        .pd0_func               (pd0_func),
        .pd7_func               (pd7_func),
        .portb_func             (portb_func),
        .pd0_owner              (pd0_owner)
    );

    // Option byte writes, reset-phase tracking and latching on release
    always_comb
    begin
        next_pin_remap_options = pin_remap_options;
        next_active_sel        = active_sel;
        next_in_reset          = 1'b0;
        if (REG_WR_IN && (REG_ADDR_IN == REG_OPTIONS_ADDR))
        begin
            next_pin_remap_options = REG_WDATA_IN;
        end
        if (in_reset)
        begin
            next_active_sel = pin_remap_options;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            pin_remap_options <= pin_remap_options; // Kept, non-volatile
            active_sel        <= OPTIONS_RESET;
            in_reset          <= 1'b1;
        end
        else
        begin
            pin_remap_options <= next_pin_remap_options;
            active_sel        <= next_active_sel;
            in_reset          <= next_in_reset;
        end
    end

    // Register read data, valid only in the cycle after the read strobe
    always_comb
    begin
        next_rdata = READ_ZERO;
        if (REG_RD_IN)
        begin
            case (REG_ADDR_IN)
                REG_OPTIONS_ADDR: next_rdata = pin_remap_options;
                REG_ACTIVE_ADDR:  next_rdata = active_sel;
                REG_CONV_ADDR:    next_rdata = {7'h00, CONV_CHANNEL_OK_OUT};
                default:          next_rdata = READ_ZERO;
            endcase
        end
    end

    // Pin routing; GPIO paths are untouched, only alternate functions move
    always_comb
    begin
        next_pb_af = 8'h00;
        next_pb_en = 8'h00;
        next_pd_af = 8'h00;
        next_pd_en = 8'h00;
        next_pb_af[3:0] = portb_func;
        next_pb_en[2:0] = {3{sel_bits[BIT_ADV_PORTB]}};
        next_pb_en[0]   = sel_bits[BIT_ADV_PORTB];
        next_pb_af[5]   = sel_bits[BIT_I2C] & I2C_SDA_OUT_IN;
        next_pb_af[4]   = sel_bits[BIT_I2C] & I2C_SCL_OUT_IN;
        next_pb_en[5]   = sel_bits[BIT_I2C];
        next_pb_en[4]   = sel_bits[BIT_I2C];
        next_pd_af[4]   = pd4_func;
        next_pd_en[4]   = 1'b1;
        next_pd_af[2]   = pd2_func;
        next_pd_en[2]   = 1'b1;
        next_pd_af[0]   = pd0_func;
        next_pd_en[0]   = (pd0_owner != PD0_BREAK);
        next_pd_af[3]   = sel_bits[BIT_CONV_TRIG] ? 1'b0 : TIMER2_CH2_IN;
        next_pd_en[3]   = !sel_bits[BIT_CONV_TRIG];
        next_pd_af[7]   = pd7_func;
        next_pd_en[7]   = sel_bits[BIT_CH4];
        // Converter channel 12 refused in scan and watchdog use
        next_conv_ok = !(CONV_SCAN_OR_WDG_IN &&
                         (CONV_CHANNEL_IN == BLOCKED_CHANNEL));
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            REG_RDATA_OUT             <= READ_ZERO;
            PORTA3_AF_OUT             <= 1'b0;
            PORTB_AF_OUT              <= 8'h00;
            PORTB_AF_EN_OUT           <= 8'h00;
            PORTD_AF_OUT              <= 8'h00;
            PORTD_AF_EN_OUT           <= 8'h00;
            ADV_TIMER_EXT_TRIGGER_OUT <= 1'b0;
            ADV_TIMER_BREAK_IN_OUT    <= 1'b0;
            CONVERTER_EXT_TRIGGER_OUT <= 1'b0;
            I2C_SDA_IN_OUT            <= 1'b1;
            I2C_SCL_IN_OUT            <= 1'b1;
            TIMER3_CH1_CAPTURE_OUT    <= 1'b0;
            PORTF_PIN4_PULLUP_OUT     <= 1'b1;
            PORTD_PIN1_PULLUP_OUT     <= 1'b1;
            CONV_CHANNEL_OK_OUT       <= 1'b1;
        end
        else
        begin
            REG_RDATA_OUT   <= next_rdata;
            PORTA3_AF_OUT   <= pa3_func;
            PORTB_AF_OUT    <= next_pb_af;
            PORTB_AF_EN_OUT <= next_pb_en;
            PORTD_AF_OUT    <= next_pd_af;
            PORTD_AF_EN_OUT <= next_pd_en;
            // Inputs from pins reach a peripheral only when remapped there, except timer 3 capture, which takes port D pin 2 by default
            ADV_TIMER_EXT_TRIGGER_OUT <= sel_bits[BIT_ADV_PORTB] &
                                         PORTB_PIN_IN[3];
            ADV_TIMER_BREAK_IN_OUT    <= (pd0_owner == PD0_BREAK) &
                                         PORTD_PIN_IN[0];
            CONVERTER_EXT_TRIGGER_OUT <= sel_bits[BIT_CONV_TRIG] &
                                         PORTD_PIN_IN[3];
            I2C_SDA_IN_OUT <= !sel_bits[BIT_I2C] | PORTB_PIN_IN[5];
            I2C_SCL_IN_OUT <= !sel_bits[BIT_I2C] | PORTB_PIN_IN[4];
            TIMER3_CH1_CAPTURE_OUT <= sel_bits[BIT_CH_SWAP] ? PORTA_PIN3_IN
                                                            : PORTD_PIN_IN[2];
            PORTF_PIN4_PULLUP_OUT <= 1'b0;
            PORTD_PIN1_PULLUP_OUT <= 1'b1;
            CONV_CHANNEL_OK_OUT   <= next_conv_ok;
        end
    end
endmodule // alt_function_remap_mux

// file: rtl/remap_pkg.sv
// Package for the alternate-function remap multiplexer.
// Assumes a single 20 MHz clock domain and a synchronous active-high reset.
package remap_pkg;
    // Register map of the plain register port
    localparam logic [1:0] REG_OPTIONS_ADDR = 2'h0;  // Option byte, read/write
    localparam logic [1:0] REG_ACTIVE_ADDR  = 2'h1;  // Latched routing, read
    localparam logic [1:0] REG_CONV_ADDR    = 2'h2;  // Converter channel check
    localparam logic [7:0] OPTIONS_RESET    = 8'h00; // Default routing
    localparam logic [7:0] READ_ZERO        = 8'h00;
    // Bit positions within the option byte
    localparam int BIT_CONV_TRIG  = 0;
    localparam int BIT_CH_SWAP    = 1;
    localparam int BIT_CLK_OUT    = 2;
    localparam int BIT_BREAK      = 3;
    localparam int BIT_CH4        = 4;
    localparam int BIT_ADV_PORTB  = 5;
    localparam int BIT_I2C        = 6;
    localparam int BIT_BEEPER_OUT       = 7;
    localparam int NUM_SEL        = 8;
    // Converter channel that the scan path and watchdog may not use
    localparam logic [3:0] BLOCKED_CHANNEL = 4'hC;
    // Port D pin 0 owner encoding
    typedef enum logic [1:0] {
        PD0_TIMER3 = 2'b00,
        PD0_BREAK  = 2'b01,
        PD0_CLKOUT = 2'b10
    } pd0_owner_type;
endpackage

// file: rtl/remap_sel_if.sv
// Interface carrying the latched remap selections between modules.
// Assumes one clock domain; producer is the top, consumer the router.
`timescale 1ns/1ps
interface remap_sel_if;
    logic [7:0] sel;  // Latched remap selections
    modport source (output sel);
    modport sink   (input  sel);
endinterface

// file: rtl/remap_router.sv
// Combinational alternate-function router for the remapped pins.
// Assumes selections stay stable between resets; outputs are registered
// by the instantiating module.
`timescale 1ns/1ps
module remap_router
    import remap_pkg::*;
(
    remap_sel_if.sink         sel_bus,
    input  wire logic         timer2_ch1,
    input  wire logic         timer2_ch3,
    input  wire logic         timer3_ch1,
    input  wire logic         timer3_ch2,
    input  wire logic         beeper_out,
    input  wire logic         adv_timer_ch4,
    input  wire logic         adv_timer_comp_ch1,
    input  wire logic         adv_timer_comp_ch2,
    input  wire logic         adv_timer_comp_ch3,
    input  wire logic         configurable_clock_out,
    input  wire logic [7:0]   pin_level,
    output logic              pd4_func,
    output logic              pd2_func,
    output logic              pa3_func,
    output logic              pd0_func,
    output logic              pd7_func,
    output logic [3:0]        portb_func,
    output pd0_owner_type     pd0_owner
);
    // Output routing per pin; a remapped function replaces the default
    always_comb
    begin
        pd4_func = sel_bus.sel[BIT_BEEPER_OUT] ? beeper_out : timer2_ch1;
        pa3_func = sel_bus.sel[BIT_CH_SWAP] ? timer3_ch1 : timer2_ch3;
        pd2_func = sel_bus.sel[BIT_CH_SWAP] ? timer2_ch3 : timer3_ch1;
        pd7_func = sel_bus.sel[BIT_CH4] ? adv_timer_ch4 : 1'b0;
        portb_func = 4'h0;
        if (sel_bus.sel[BIT_ADV_PORTB])
        begin
            portb_func = {1'b0, adv_timer_comp_ch3, adv_timer_comp_ch2,
                          adv_timer_comp_ch1};
        end
        // Clock output wins over break on port D pin 0
        if (sel_bus.sel[BIT_CLK_OUT])
        begin
            pd0_owner = PD0_CLKOUT;
        end
        else if (sel_bus.sel[BIT_BREAK])
        begin
            pd0_owner = PD0_BREAK;
        end
        else
        begin
            pd0_owner = PD0_TIMER3;
        end
        case (pd0_owner)
            PD0_CLKOUT: pd0_func = configurable_clock_out;
            PD0_BREAK:  pd0_func = 1'b0; // Pin is an input to the timer
            PD0_TIMER3: pd0_func = timer3_ch2;
            default:    pd0_func = timer3_ch2;
        endcase
    end
    // pin_level is used by the top module for input routing
    wire unused_levels = ^pin_level;
endmodule // remap_router

// file: testbench/periph_model.sv
// Peripheral-side model: timer, beeper, clock-out and I2C driver levels.
// Assumes one clock; every level moves often so a stuck route shows up.
`timescale 1ns/1ps
module periph_model
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    output logic      [12:0] level_out
);
    logic [12:0] next_level;

    // The peripheral level vector steps by 13'h00B5 each cycle
    always_comb
    begin
        next_level = level_out + 13'h00B5;
    end

    // Level register, cleared by reset
    always_ff @(posedge clk_in)
    begin
        level_out <= rst_in ? 13'h0000 : next_level;
    end
endmodule // periph_model

// file: testbench/alt_function_remap_mux_sva.sv
// Checker for the remap multiplexer: register port, routing, reset pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module remap_mux_sva
    import remap_pkg::*;
(
    input wire logic       CLK_IN,
    input wire logic       SYS_RST_IN,
    input wire logic [1:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic       REG_WR_IN,
    input wire logic       REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic       TIMER2_CH1_IN,
    input wire logic       TIMER3_CH2_IN,
    input wire logic       BEEPER_OUT_IN,
    input wire logic       CONFIGURABLE_CLOCK_OUT_IN,
    input wire logic [7:0] PORTD_PIN_IN,
    input wire logic       PORTA_PIN3_IN,
    input wire logic [3:0] CONV_CHANNEL_IN,
    input wire logic       CONV_SCAN_OR_WDG_IN,
    input wire logic [7:0] PORTD_AF_OUT,
    input wire logic       ADV_TIMER_BREAK_IN_OUT,
    input wire logic       TIMER3_CH1_CAPTURE_OUT,
    input wire logic       PORTF_PIN4_PULLUP_OUT,
    input wire logic       CONV_CHANNEL_OK_OUT
);
    logic [7:0] opt;
    logic [7:0] act;
    logic       opt_ok = 1'b0;
    logic       was_rst;
    logic       live;

    // Shadow option byte; routing copy taken at the first edge after reset
    always_ff @(posedge CLK_IN)
    begin
        if (REG_WR_IN && REG_ADDR_IN == REG_OPTIONS_ADDR)
        begin
            opt    <= REG_WDATA_IN;
            opt_ok <= 1'b1;
        end
        was_rst <= SYS_RST_IN;
        live    <= !SYS_RST_IN && (was_rst ? opt_ok : live);
        if (was_rst && !SYS_RST_IN)
            act <= opt;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_opt_readback: assert property (REG_RD_IN && opt_ok &&
        REG_ADDR_IN == REG_OPTIONS_ADDR |=> REG_RDATA_OUT == opt)
        else $error("option byte read back wrong");
    a_active_fixed: assert property (REG_RD_IN && live &&
        REG_ADDR_IN == REG_ACTIVE_ADDR |=> REG_RDATA_OUT == act)
        else $error("active routing not the latched byte");
    a_f4_in_reset: assert property ($fell(SYS_RST_IN) |->
        PORTF_PIN4_PULLUP_OUT)
        else $error("port F pin 4 pull-up missing in reset");
    a_f4_floating: assert property (!$past(SYS_RST_IN) |->
        !PORTF_PIN4_PULLUP_OUT)
        else $error("port F pin 4 pull-up left on");
    a_ch12_block: assert property (1'b1 |=> CONV_CHANNEL_OK_OUT ==
        !($past(CONV_CHANNEL_IN) == BLOCKED_CHANNEL &&
        $past(CONV_SCAN_OR_WDG_IN)))
        else $error("converter channel guard wrong");
    a_beeper_out_pin: assert property (live |=> PORTD_AF_OUT[4] ==
        (act[BIT_BEEPER_OUT] ? $past(BEEPER_OUT_IN) : $past(TIMER2_CH1_IN)))
        else $error("port D pin 4 routing wrong");
    a_d0_owner: assert property (live &&
        (act[BIT_CLK_OUT] || !act[BIT_BREAK]) |=> PORTD_AF_OUT[0] ==
        (act[BIT_CLK_OUT] ? $past(CONFIGURABLE_CLOCK_OUT_IN) :
        $past(TIMER3_CH2_IN)))
        else $error("port D pin 0 routing wrong");
    a_break_in: assert property (live |=>
        ADV_TIMER_BREAK_IN_OUT == (act[BIT_BREAK] && !act[BIT_CLK_OUT] &&
        $past(PORTD_PIN_IN[0])))
        else $error("break input routing wrong");
    a_swap_capture: assert property (live |=>
        TIMER3_CH1_CAPTURE_OUT == (act[BIT_CH_SWAP] ?
        $past(PORTA_PIN3_IN) : $past(PORTD_PIN_IN[2])))
        else $error("timer 3 capture routing wrong");
    a_rdata_idle: assert property (!REG_RD_IN |=>
        REG_RDATA_OUT == READ_ZERO)
        else $error("read data not zero outside a read");
endmodule // remap_mux_sva

bind alt_function_remap_mux remap_mux_sva remap_mux_sva_i (.*);

// file: testbench/alt_function_remap_mux_tb_top.sv
// Testbench for the remap multiplexer: registers, routing, reset pins.
// Assumes the peripheral model drives every peripheral level input.
`timescale 1ns/1ps
module alt_function_remap_mux_tb_top
    import remap_pkg::*;
;
    logic       CLK_IN = 1'b0, SYS_RST_IN = 1'b1, REG_WR_IN = 1'b0;
    logic       REG_RD_IN = 1'b0, PORTA_PIN3_IN = 1'b0;
    logic       CONV_SCAN_OR_WDG_IN = 1'b0;
    logic [1:0] REG_ADDR_IN = 2'h0;
    logic [3:0] CONV_CHANNEL_IN = 4'h0;
    logic [7:0] REG_WDATA_IN = 8'h00, PORTB_PIN_IN = 8'h00;
    logic [7:0] PORTD_PIN_IN = 8'h00;
    logic [12:0] lvl;
    wire TIMER2_CH1_IN, TIMER2_CH2_IN, TIMER2_CH3_IN, TIMER3_CH1_IN;
    wire TIMER3_CH2_IN, BEEPER_OUT_IN, ADV_TIMER_CH4_IN, I2C_SCL_OUT_IN;
    wire ADV_TIMER_COMP_CH1_IN, ADV_TIMER_COMP_CH2_IN, I2C_SDA_OUT_IN;
    wire ADV_TIMER_COMP_CH3_IN, CONFIGURABLE_CLOCK_OUT_IN;
    wire [7:0] REG_RDATA_OUT, PORTD_AF_OUT, PORTB_AF_OUT, PORTB_AF_EN_OUT;
    wire [7:0] PORTD_AF_EN_OUT;
    wire I2C_SCL_IN_OUT;
    wire PORTA3_AF_OUT, ADV_TIMER_EXT_TRIGGER_OUT, ADV_TIMER_BREAK_IN_OUT;
    wire CONVERTER_EXT_TRIGGER_OUT, I2C_SDA_IN_OUT, TIMER3_CH1_CAPTURE_OUT;
    wire PORTF_PIN4_PULLUP_OUT, PORTD_PIN1_PULLUP_OUT, CONV_CHANNEL_OK_OUT;
    wire [7:0] route = {PORTD_AF_OUT[4], PORTD_AF_OUT[0], PORTA3_AF_OUT,
        I2C_SDA_IN_OUT, ADV_TIMER_EXT_TRIGGER_OUT, CONVERTER_EXT_TRIGGER_OUT,
        TIMER3_CH1_CAPTURE_OUT, ADV_TIMER_BREAK_IN_OUT};
    wire [7:0] pulls = {6'h00, PORTF_PIN4_PULLUP_OUT, PORTD_PIN1_PULLUP_OUT};
    // One remap bit per entry, save the 0C priority pair and the 00 default
    logic [7:0] sels [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
        8'h0C, 8'h02, 8'h01, 8'h00};
    int bad_count = 0;
    int comparisons = 0;

    // Peripheral levels fanned out to the design inputs
    assign {TIMER2_CH1_IN, TIMER2_CH2_IN, TIMER2_CH3_IN, TIMER3_CH1_IN,
        TIMER3_CH2_IN, BEEPER_OUT_IN, ADV_TIMER_CH4_IN, ADV_TIMER_COMP_CH1_IN,
        ADV_TIMER_COMP_CH2_IN, ADV_TIMER_COMP_CH3_IN, I2C_SDA_OUT_IN,
        CONFIGURABLE_CLOCK_OUT_IN, I2C_SCL_OUT_IN} = lvl;

    periph_model periph_model_i (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
        .level_out(lvl));

    alt_function_remap_mux alt_function_remap_mux_i (.CLK_IN, .SYS_RST_IN,
        .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT,
        .TIMER2_CH1_IN, .TIMER2_CH2_IN, .TIMER2_CH3_IN, .TIMER3_CH1_IN,
        .TIMER3_CH2_IN, .BEEPER_OUT_IN, .ADV_TIMER_CH4_IN,
        .ADV_TIMER_COMP_CH1_IN, .ADV_TIMER_COMP_CH2_IN,
        .ADV_TIMER_COMP_CH3_IN, .CONFIGURABLE_CLOCK_OUT_IN, .I2C_SDA_OUT_IN,
        .I2C_SCL_OUT_IN, .PORTB_PIN_IN, .PORTD_PIN_IN, .PORTA_PIN3_IN,
        .CONV_CHANNEL_IN, .CONV_SCAN_OR_WDG_IN, .PORTA3_AF_OUT,
        .PORTB_AF_OUT, .PORTB_AF_EN_OUT, .PORTD_AF_OUT,
        .PORTD_AF_EN_OUT, .ADV_TIMER_EXT_TRIGGER_OUT,
        .ADV_TIMER_BREAK_IN_OUT, .CONVERTER_EXT_TRIGGER_OUT, .I2C_SDA_IN_OUT,
        .I2C_SCL_IN_OUT, .TIMER3_CH1_CAPTURE_OUT, .PORTF_PIN4_PULLUP_OUT,
        .PORTD_PIN1_PULLUP_OUT, .CONV_CHANNEL_OK_OUT);

    // 20 MHz clock
    initial
    begin
        forever #25 CLK_IN = ~CLK_IN;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        REG_WR_IN    <= 1'b1;
        REG_ADDR_IN  <= a;
        REG_WDATA_IN <= d;
        @(posedge CLK_IN);
        REG_WR_IN <= 1'b0;
    endtask

    // Read strobe for one cycle; data judged in the following cycle
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge CLK_IN);
        REG_RD_IN   <= 1'b1;
        REG_ADDR_IN <= a;
        @(posedge CLK_IN);
        REG_RD_IN <= 1'b0;
        #1;
        check(REG_RDATA_OUT, exp);
    endtask

    // Reset of n+1 edges with the pull-ups judged inside and after it
    task automatic pulse_reset(input int n);
        @(posedge CLK_IN);
        SYS_RST_IN <= 1'b1;
        repeat (n) @(posedge CLK_IN);
        #1;
        check(pulls, 8'h03);
        @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        #1;
        check(pulls, 8'h01);
    endtask

    // Latch one selection, change the option byte, routing must stay put
    task automatic t_route(input logic [7:0] s);
        logic [7:0] e;
        logic [7:0] pb;
        logic [7:0] pd;
        logic [7:0] pbe;
        logic [7:0] pde;
        logic       scl;
        wr(REG_OPTIONS_ADDR, s);
        pulse_reset(1);
        rdchk(REG_ACTIVE_ADDR, s);
        wr(REG_OPTIONS_ADDR, ~s);
        rdchk(REG_OPTIONS_ADDR, ~s);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge CLK_IN);
            PORTB_PIN_IN  <= {8{k[0]}} ^ 8'h28;
            PORTD_PIN_IN  <= {8{k[1]}} ^ 8'h05;
            PORTA_PIN3_IN <= k[0] ^ k[1];
            @(negedge CLK_IN);
            e = {s[7] ? BEEPER_OUT_IN : TIMER2_CH1_IN,
                s[2] ? CONFIGURABLE_CLOCK_OUT_IN : (!s[3] && TIMER3_CH2_IN),
                s[1] ? TIMER3_CH1_IN : TIMER2_CH3_IN,
                !s[6] || PORTB_PIN_IN[5], s[5] && PORTB_PIN_IN[3],
                s[0] && PORTD_PIN_IN[3],
                s[1] ? PORTA_PIN3_IN : PORTD_PIN_IN[2],
                s[3] && !s[2] && PORTD_PIN_IN[0]};
            // Port B and D drive values; break mode leaves pin 0 undriven
            pb = {2'b00, s[6] && I2C_SDA_OUT_IN, s[6] && I2C_SCL_OUT_IN, 1'b0,
                s[5] && ADV_TIMER_COMP_CH3_IN, s[5] && ADV_TIMER_COMP_CH2_IN,
                s[5] && ADV_TIMER_COMP_CH1_IN};
            pd = {s[4] && ADV_TIMER_CH4_IN, 2'b00, e[7],
                !s[0] && TIMER2_CH2_IN,
                s[1] ? TIMER2_CH3_IN : TIMER3_CH1_IN, 1'b0, e[6]};
            pbe = {2'b00, {2{s[6]}}, 1'b0, {3{s[5]}}};
            pde = {s[4], 3'b001, !s[0], 2'b10, s[2] || !s[3]};
            scl = !s[6] || PORTB_PIN_IN[4];
            @(posedge CLK_IN);
            #1;
            check(route, e);
            check(PORTB_AF_OUT, pb);
            check(PORTD_AF_OUT, pd);
            check(PORTB_AF_EN_OUT, pbe);
            check(PORTD_AF_EN_OUT, pde);
            check({7'h00, I2C_SCL_IN_OUT}, {7'h00, scl});
        end
    endtask

    // Channel 12 refused only for scan or watchdog use
    task automatic t_conv();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge CLK_IN);
            {CONV_CHANNEL_IN, CONV_SCAN_OR_WDG_IN} <= 5'h19 - 5'(i);
            @(posedge CLK_IN);
            #1;
            check({7'h00, CONV_CHANNEL_OK_OUT}, {7'h00, i != 0});
            rdchk(REG_CONV_ADDR, {7'h00, i != 0});
        end
    endtask

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge CLK_IN);
        bad_count++;
        summarize();
    end

    initial
    begin
        pulse_reset(10);
        for (int i = 0; i < 10; i++)
            t_route(sels[i]);
        wr(REG_ACTIVE_ADDR, 8'hA5);
        rdchk(REG_ACTIVE_ADDR, 8'h00);
        rdchk(2'h3, READ_ZERO);
        t_conv();
        summarize();
    end
endmodule // alt_function_remap_mux_tb_top
